// file: irf_pkg.sv
// Constants and types shared by the flag bank and its controller
// Assumes one 10 MHz clock and synchronous active-low reset
package irf_pkg;

  // ----------------------------------------------------------
  // Register map of the flag bank
  // ----------------------------------------------------------
  localparam int         IRF_DW             = 8;
  localparam int         IRF_AW             = 7;
  localparam logic [6:0] IRF_FLAGS_OFS      = 7'h0c;
  localparam logic [6:0] IRF_CAUSE_OFS      = 7'h0c;
  localparam logic       IRF_BANK_FLAGS     = 1'b0;
  localparam logic       IRF_BANK_CAUSE     = 1'b1;
  localparam int         IRF_EE_BIT         = 7;
  localparam int         IRF_CMP_BIT        = 6;
  localparam int         IRF_RX_BIT         = 5;
  localparam int         IRF_TX_BIT         = 4;
  localparam int         IRF_CC_BIT         = 2;
  localparam int         IRF_PM_BIT         = 1;
  localparam int         IRF_TOV_BIT        = 0;
  localparam int         IRF_OSC_FREQ_SELECT_BIT       = 3;
  localparam int         IRF_POR_BIT        = 1;
  localparam int         IRF_BOD_BIT        = 0;
  localparam logic [7:0] IRF_FLAGS_WR_MASK  = 8'hc7;
  localparam logic [7:0] IRF_FLAGS_RST      = 8'h00;
  localparam logic       IRF_OSC_FREQ_SELECT_RST       = 1'b1;
  localparam logic       IRF_BOD_POR_VAL    = 1'b0;

  typedef enum logic [1:0]
  {
    IRF_RST_POR,
    IRF_RST_BOR,
    IRF_RST_PIN,
    IRF_RST_WDT
  } irf_rst_cause_t;

  // ----------------------------------------------------------
  // Controller register map (AXI4-Lite)
  // ----------------------------------------------------------
  localparam logic [7:0] IRF_CMD_OFS       = 8'h00;
  localparam logic [7:0] IRF_STAT_OFS      = 8'h04;
  localparam logic [7:0] IRF_ISTAT_OFS     = 8'h08;
  localparam logic [7:0] IRF_IMASK_OFS     = 8'h0c;
  localparam int         IRF_CMD_ADDR_LSB  = 8;
  localparam int         IRF_CMD_BANK_BIT  = 15;
  localparam int         IRF_CMD_WR_BIT    = 16;
  localparam int         IRF_STAT_BUSY_BIT = 8;
  localparam int         IRF_STAT_ERR_BIT  = 9;
  localparam logic [1:0] IRF_RESP_OKAY     = 2'b00;
  localparam logic [1:0] IRF_RESP_SLVERR   = 2'b10;

  typedef enum logic
  {
    IRF_IDLE,
    IRF_BUSY
  } irf_state_t;

endpackage

// file: irf_link_if.sv
// Register access link between controller and flag bank
// Assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface irf_link_if;
  import irf_pkg::*;
  logic              acc_valid;
  logic              acc_write;
  logic              acc_bank;
  logic [IRF_AW-1:0] acc_addr;
  logic [IRF_DW-1:0] acc_wdata;
  logic [IRF_DW-1:0] acc_rdata;
  logic              acc_done;
  logic              acc_err;

  modport dev
  (
    input  acc_valid,
    input  acc_write,
    input  acc_bank,
    input  acc_addr,
    input  acc_wdata,
    output acc_rdata,
    output acc_done,
    output acc_err
  );

  modport ctl
  (
    output acc_valid,
    output acc_write,
    output acc_bank,
    output acc_addr,
    output acc_wdata,
    input  acc_rdata,
    input  acc_done,
    input  acc_err
  );
endinterface
`default_nettype wire

// file: irf_dev.sv
// Peripheral interrupt flag and reset cause register bank
// Assumes peripheral events are one-cycle pulses on aclk and the
// reset cause is valid while aresetn is low
//
// Contract
// - Flags latch on events regardless of enables; RX and TX bits follow serial_rx_full and serial_tx_empty
// - Software clears stale flags before enabling
// - Flag register holds only peripheral flags
// - Cause bits distinguish power-on and brown-out; pin and watchdog read alike
// - Cause bit 3 selects fast or slow oscillator
// - External resistor mode uses resistor-set frequency
// - Bit 1 zero after power-on; software sets
// - Bit 0 zero after brown-out; software sets
// - Brown-out bit undefined after power-on
// - Brown-out bit meaningless when circuit disabled
// - Unimplemented bits always read zero
`timescale 1ns/1ps
`default_nettype none
module irf_dev
  import irf_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  irf_link_if.dev           link,
  input  wire irf_rst_cause_t reset_cause,
  input  wire logic         brownout_circuit_enable,
  input  wire logic         eeprom_write_done_ev,
  input  wire logic         comparator_change_ev,
  input  wire logic         serial_rx_full,
  input  wire logic         serial_tx_empty,
  input  wire logic         capture_compare_ev,
  input  wire logic         period_match_ev,
  input  wire logic         timer_overflow_ev,
  input  wire logic         external_resistor_osc,
  output logic [7:0]        peripheral_irq_flags,
  output logic              osc_fast,
  output logic              osc_use_resistor,
  output logic              osc_slow
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic       osc_freq_select_q;
  logic       osc_freq_select_d;
  logic       por_q;
  logic       por_d;
  logic       bod_q;
  logic       bod_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       done_q;
  logic       err_q;
  logic       err_d;

  // ----------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------
  function automatic logic reg_hit(input logic              bank_sel,
                                   input logic [IRF_AW-1:0] ofs,
                                   input logic              want_bank,
                                   input logic [IRF_AW-1:0] want_ofs);
    return (bank_sel == want_bank) & (ofs == want_ofs);
  endfunction

  wire take      = link.acc_valid & ~done_q;
  wire hit_flags = reg_hit(link.acc_bank, link.acc_addr,
                           IRF_BANK_FLAGS, IRF_FLAGS_OFS);
  wire hit_cause = reg_hit(link.acc_bank, link.acc_addr,
                           IRF_BANK_CAUSE, IRF_CAUSE_OFS);
  wire wr_flags  = take & link.acc_write & hit_flags;
  wire wr_cause  = take & link.acc_write & hit_cause;

  // ----------------------------------------------------------
  // Peripheral flags
  // ----------------------------------------------------------
  logic [7:0] ev;
  logic [7:0] live;
  logic [7:0] flags_rd;
  always_comb
  begin
    ev               = 8'h00;
    ev[IRF_EE_BIT]   = eeprom_write_done_ev;
    ev[IRF_CMP_BIT]  = comparator_change_ev;
    ev[IRF_CC_BIT]   = capture_compare_ev;
    ev[IRF_PM_BIT]   = period_match_ev;
    ev[IRF_TOV_BIT]  = timer_overflow_ev;
    live             = 8'h00;
    live[IRF_RX_BIT] = serial_rx_full;
    live[IRF_TX_BIT] = serial_tx_empty;
  end

  // Event set wins over a software write in the same cycle
  for (genvar i = 0; i < IRF_DW; i++)
  begin : g_flag
    if (IRF_FLAGS_WR_MASK[i])
    begin : g_rw
      assign flags_d[i] = (wr_flags ? link.acc_wdata[i] : flags_q[i])
                        | ev[i];
    end
    else
    begin : g_ro
      assign flags_d[i] = 1'b0;
    end
  end
  assign flags_rd = flags_q | live;

  // ----------------------------------------------------------
  // Reset cause and oscillator select
  // ----------------------------------------------------------
  wire cause_por = (reset_cause == IRF_RST_POR);
  wire cause_bor = (reset_cause == IRF_RST_BOR)
                 & brownout_circuit_enable;

  assign osc_freq_select_d = wr_cause ? link.acc_wdata[IRF_OSC_FREQ_SELECT_BIT] : osc_freq_select_q;
  assign por_d  = wr_cause ? link.acc_wdata[IRF_POR_BIT]  : por_q;
  assign bod_d  = wr_cause ? link.acc_wdata[IRF_BOD_BIT]  : bod_q;

  logic [7:0] cause_rd;
  always_comb
  begin
    cause_rd               = 8'h00;
    cause_rd[IRF_OSC_FREQ_SELECT_BIT] = osc_freq_select_q;
    cause_rd[IRF_POR_BIT]  = por_q;
    cause_rd[IRF_BOD_BIT]  = bod_q;
  end

  // ----------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------
  assign rdata_d = hit_flags ? flags_rd
                 : hit_cause ? cause_rd
                 : 8'h00;
  assign err_d   = ~(hit_flags | hit_cause);

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  // Flags clear and the fast oscillator is chosen on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= IRF_FLAGS_RST;
      osc_freq_select_q  <= IRF_OSC_FREQ_SELECT_RST;
    end
    else
    begin
      flags_q <= flags_d;
      osc_freq_select_q  <= osc_freq_select_d;
    end
  end

  // Cause bits take the reason of the reset while it is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_q <= ~cause_por;
      if (cause_por)
      begin
        bod_q <= IRF_BOD_POR_VAL;
      end
      else if (cause_bor)
      begin
        bod_q <= 1'b0;
      end
    end
    else
    begin
      por_q <= por_d;
      bod_q <= bod_d;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      done_q <= take;
      if (take)
      begin
        err_q   <= err_d;
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign link.acc_rdata       = rdata_q;
  assign link.acc_done        = done_q;
  assign link.acc_err         = err_q;
  assign peripheral_irq_flags = flags_rd;

  // ----------------------------------------------------------
  // Oscillator select
  // ----------------------------------------------------------
  assign osc_fast             = osc_freq_select_q & ~external_resistor_osc;
  assign osc_use_resistor     = osc_freq_select_q & external_resistor_osc;
  assign osc_slow             = ~osc_freq_select_q;

endmodule
`default_nettype wire

// file: irf_ctl.sv
// AXI4-Lite controller that issues single accesses to the flag bank
// Assumes one access at a time and a bank that answers by acc_done
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module irf_ctl
  import irf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  irf_link_if.ctl          link
);

  // ----------------------------------------------------------
  // AXI write side
  // ----------------------------------------------------------
  logic        aw_q;
  logic        w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  wire   do_wr   = aw_q & w_q & ~bvalid_q;
  wire   wr_cmd  = do_wr & (awaddr_q == IRF_CMD_OFS);
  wire   wr_ist  = do_wr & (awaddr_q == IRF_ISTAT_OFS);
  wire   wr_msk  = do_wr & (awaddr_q == IRF_IMASK_OFS);
  wire   wr_ok   = wr_cmd | wr_ist | wr_msk
                 | (awaddr_q == IRF_STAT_OFS);

  // ----------------------------------------------------------
  // Command and link
  // ----------------------------------------------------------
  irf_state_t  state_q;
  logic [16:0] cmd_q;
  logic [7:0]  rd_q;
  logic        err_q;
  logic        istat_q;
  logic        imask_q;

  wire busy     = (state_q == IRF_BUSY);
  wire start    = wr_cmd & ~busy;
  wire done_ev  = busy & link.acc_done;
  wire istat_d  = (istat_q & ~(wr_ist & wdata_q[0])) | done_ev;

  assign link.acc_valid = busy;
  assign link.acc_write = cmd_q[IRF_CMD_WR_BIT];
  assign link.acc_bank  = cmd_q[IRF_CMD_BANK_BIT];
  assign link.acc_addr  = cmd_q[IRF_CMD_ADDR_LSB +: IRF_AW];
  assign link.acc_wdata = cmd_q[7:0];
  assign irq            = istat_q & imask_q;

  // ----------------------------------------------------------
  // AXI read decode
  // ----------------------------------------------------------
  wire [31:0] stat_word = {22'h00_0000, err_q, busy, rd_q};
  wire        rd_hit    = (s_axi_araddr == IRF_CMD_OFS)
                        | (s_axi_araddr == IRF_STAT_OFS)
                        | (s_axi_araddr == IRF_ISTAT_OFS)
                        | (s_axi_araddr == IRF_IMASK_OFS);
  wire [31:0] rd_mux    =
      (s_axi_araddr == IRF_CMD_OFS)   ? {15'h0000, cmd_q}
    : (s_axi_araddr == IRF_STAT_OFS)  ? stat_word
    : (s_axi_araddr == IRF_ISTAT_OFS) ? {31'h0000_0000, istat_q}
    : (s_axi_araddr == IRF_IMASK_OFS) ? {31'h0000_0000, imask_q}
    : 32'h0000_0000;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q  <= IRF_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_wr)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? IRF_RESP_OKAY : IRF_RESP_SLVERR;
      end
      else if (bvalid_q & s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= IRF_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? IRF_RESP_OKAY : IRF_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= IRF_IDLE;
      cmd_q   <= 17'h0_0000;
      rd_q    <= 8'h00;
      err_q   <= 1'b0;
      istat_q <= 1'b0;
      imask_q <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      if (wr_msk)
      begin
        imask_q <= wdata_q[0];
      end
      case (state_q)
        IRF_IDLE:
        begin
          if (start)
          begin
            cmd_q   <= wdata_q[16:0];
            state_q <= IRF_BUSY;
          end
        end
        IRF_BUSY:
        begin
          if (link.acc_done)
          begin
            rd_q    <= link.acc_rdata;
            err_q   <= link.acc_err;
            state_q <= IRF_IDLE;
          end
        end
        default:
        begin
          state_q <= IRF_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: irf_chk.sv
// Concurrent checks on the link between controller and flag bank
// Assumes one clock aclk and synchronous active-low reset aresetn
`timescale 1ns/1ps
`default_nettype none
module irf_chk
  import irf_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              acc_valid,
  input wire logic              acc_write,
  input wire logic              acc_bank,
  input wire logic [IRF_AW-1:0] acc_addr,
  input wire logic [IRF_DW-1:0] acc_wdata,
  input wire logic [IRF_DW-1:0] acc_rdata,
  input wire logic              acc_done,
  input wire logic              acc_err
);
  // ----------------------------------------------------------
  // Oscillator select shadow
  // ----------------------------------------------------------
  logic osc_q;
  always_ff @(posedge aclk)
    if (!aresetn)
      osc_q <= IRF_OSC_FREQ_SELECT_RST;
    else if (acc_done && acc_write && acc_bank && !acc_err)
      osc_q <= acc_wdata[IRF_OSC_FREQ_SELECT_BIT];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  done_timing_a:
    assert property (acc_valid && !acc_done |=> acc_done)
    else $error("link answer not one cycle after request");
  done_pulse_a:
    assert property (acc_done |=> !acc_done)
    else $error("link done longer than one cycle");
  valid_gap_a:
    assert property (acc_done |=> !acc_valid)
    else $error("link request not dropped after done");
  req_hold_a:
    assert property (acc_valid && !acc_done |=>
      $stable({acc_write, acc_bank, acc_addr, acc_wdata}))
    else $error("link request changed before done");
  rdata_hold_a:
    assert property (!acc_done |-> $stable({acc_rdata, acc_err}))
    else $error("read data moved between accesses");
  err_zero_a:
    assert property (acc_done && acc_err |-> acc_rdata == 8'h00)
    else $error("unmapped access returned data");
  map_ok_a:
    assert property (acc_done && acc_addr == IRF_FLAGS_OFS |-> !acc_err)
    else $error("mapped register flagged as error");
  flag_gap_a:
    assert property (acc_done && !acc_bank && !acc_write |-> !acc_rdata[3])
    else $error("unused flag bit read as one");
  cause_gap_a:
    assert property (acc_done && acc_bank && !acc_write |->
      acc_rdata[7:4] == 4'h0 && !acc_rdata[2])
    else $error("unused cause bits read as one");
  osc_track_a:
    assert property (acc_done && acc_bank && !acc_write && !acc_err |->
      acc_rdata[IRF_OSC_FREQ_SELECT_BIT] == osc_q)
    else $error("oscillator select bit lost");
endmodule
`default_nettype wire

// file: irq_flags_reset_cause_regs_tb.sv
// Self-checking bench for the flag bank and its AXI4-Lite controller
// Assumes the controller map and bank register map given in irf_pkg
`timescale 1ns/1ps
`default_nettype none
module irq_flags_reset_cause_regs_tb;
  import irf_pkg::*;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [7:0]     s_axi_awaddr = '0;
  logic           s_axi_awvalid = 1'b0;
  logic [31:0]    s_axi_wdata = '0;
  logic [3:0]     s_axi_wstrb = 4'hf;
  logic           s_axi_wvalid = 1'b0;
  logic           s_axi_bready = 1'b0;
  logic [7:0]     s_axi_araddr = '0;
  logic           s_axi_arvalid = 1'b0;
  logic           s_axi_rready = 1'b0;
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic           s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]     s_axi_bresp, s_axi_rresp, r;
  logic [31:0]    s_axi_rdata, s;
  irf_rst_cause_t reset_cause = IRF_RST_POR;
  logic           brownout_circuit_enable = 1'b1;
  logic           external_resistor_osc = 1'b0;
  logic [7:0]     ev = '0;
  logic [7:0]     peripheral_irq_flags;
  logic           osc_fast, osc_use_resistor, osc_slow;
  int             fails = 0;
  int             tests_run = 0;

  initial forever #50 aclk = ~aclk;

  irf_link_if link ();
  irf_ctl u_irf_ctl
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .link
  );
  irf_dev u_irf_dev
  (
    .aclk, .aresetn, .link, .reset_cause, .brownout_circuit_enable,
    .eeprom_write_done_ev(ev[7]), .comparator_change_ev(ev[6]),
    .serial_rx_full(ev[5]), .serial_tx_empty(ev[4]),
    .capture_compare_ev(ev[2]), .period_match_ev(ev[1]),
    .timer_overflow_ev(ev[0]), .external_resistor_osc,
    .peripheral_irq_flags, .osc_fast, .osc_use_resistor, .osc_slow
  );
  irf_chk u_irf_chk
  (
    .aclk, .aresetn, .acc_valid(link.acc_valid),
    .acc_write(link.acc_write), .acc_bank(link.acc_bank),
    .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata),
    .acc_rdata(link.acc_rdata), .acc_done(link.acc_done),
    .acc_err(link.acc_err)
  );

  // ----------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    s = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic acc(input logic w, b, input logic [6:0] a,
                     input logic [7:0] d);
    wr(IRF_CMD_OFS, {15'h0000, w, b, a, d});
    do
    begin
      rd(IRF_STAT_OFS);
    end
    while (s[IRF_STAT_BUSY_BIT]);
  endtask

  task automatic wreg(input logic b, input logic [7:0] d);
    acc(1'b1, b, IRF_FLAGS_OFS, d);
  endtask

  task automatic rchk(input logic b, input logic [7:0] e);
    acc(1'b0, b, IRF_FLAGS_OFS, 8'h00);
    chk(s[9:0], {2'b00, e});
  endtask

  task automatic rst(input irf_rst_cause_t c);
    @(posedge aclk);
    reset_cause <= c;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 8'h00;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_por;
    rchk(1'b0, 8'h00);
    rchk(1'b1, 8'h08);
    chk({osc_fast, osc_use_resistor, osc_slow}, 3'b100);
    $display("test power-on values done");
  endtask

  task automatic t_flags;
    int q[5] = '{7, 6, 2, 1, 0};
    foreach (q[i])
    begin
      pulse(8'h01 << q[i]);
      rchk(1'b0, 8'h01 << q[i]);
      rchk(1'b0, 8'h01 << q[i]);
      wreg(1'b0, 8'h00);
    end
    @(posedge aclk);
    ev <= 8'h38;
    wreg(1'b0, 8'hff);
    chk(peripheral_irq_flags, 8'hf7);
    rchk(1'b0, 8'hf7);
    @(posedge aclk);
    ev <= 8'h00;
    rchk(1'b0, 8'hc7);
    wreg(1'b0, 8'h00);
    rchk(1'b0, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_cause;
    wreg(1'b1, 8'hf7);
    rchk(1'b1, 8'h03);
    chk({osc_fast, osc_use_resistor, osc_slow}, 3'b001);
    @(posedge aclk);
    external_resistor_osc <= 1'b1;
    wreg(1'b1, 8'h0b);
    rchk(1'b1, 8'h0b);
    chk({osc_fast, osc_use_resistor, osc_slow}, 3'b010);
    @(posedge aclk);
    external_resistor_osc <= 1'b0;
    @(posedge aclk);
    chk({osc_fast, osc_use_resistor, osc_slow}, 3'b100);
    $display("test cause register done");
  endtask

  task automatic t_resets;
    irf_rst_cause_t c[4] = '{IRF_RST_PIN, IRF_RST_WDT, IRF_RST_BOR,
                             IRF_RST_POR};
    logic [7:0] e[4] = '{8'h0b, 8'h0b, 8'h0a, 8'h08};
    foreach (c[i])
    begin
      wreg(1'b0, 8'hc7);
      wreg(1'b1, 8'h03);
      rst(c[i]);
      rchk(1'b1, e[i]);
      rchk(1'b0, 8'h00);
    end
    @(posedge aclk);
    brownout_circuit_enable <= 1'b0;
    wreg(1'b1, 8'h03);
    rst(IRF_RST_BOR);
    rchk(1'b1, 8'h0b);
    @(posedge aclk);
    brownout_circuit_enable <= 1'b1;
    $display("test reset causes done");
  endtask

  task automatic t_irq;
    wr(IRF_IMASK_OFS, 32'h0000_0000);
    rchk(1'b0, 8'h00);
    rd(IRF_ISTAT_OFS);
    chk({s[0], irq}, 2'b10);
    wr(IRF_IMASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(IRF_ISTAT_OFS, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(8'h10, 32'h0000_0000);
    chk(r, IRF_RESP_SLVERR);
    rd(8'h14);
    chk({r, s}, {IRF_RESP_SLVERR, 32'h0000_0000});
    acc(1'b0, 1'b0, 7'h0d, 8'h00);
    chk(s[9:0], 10'h200);
    rd(IRF_CMD_OFS);
    chk(s, 32'h0000_0d00);
    rd(IRF_IMASK_OFS);
    chk(s, 32'h0000_0001);
    $display("test interrupt and errors done");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_por;
    t_flags;
    t_cause;
    t_resets;
    t_irq;
    report_and_stop;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
